// ### src/lfa_core.sv
// lfa_core: link fault signalling, block coding, error insertion and link alarm
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - phy local fault makes us transmit the remote fault ordered set
// - received remote fault replaces mac data with idle blocks
// - fault message is a 4-byte ordered set, local or remote variant only
// - transmit payload scrambled, then 2-bit sync header added, 66-bit block
// - receive strips sync header and descrambles to recover the 64-bit word
// - insertion sends bad-block run then good-block run, each at least 2
// - insertion sends type A only or alternates; runs once or loops
// - link alarm output is active low and flags a link problem
// - alarm asserts only for faults whose enable bits are set
// - each alarm control register is 16 bits, written whole
// - receive enable bits 9,5,4,3,0; bits 15 to 11 read zero
// - receive enables reset to one
// - transmit enable bits 9,8,7,6,4,3,0
// - transmit enables reset to one; bits 15 to 11 read zero
// - global mask bit 2 receive, 1 transmit, 0 link state; reset zero
// - readable unique identifier lets host recognise the transceiver
// - one setting turns alarm monitoring on or off as a whole
module lfa_core
    import lfa_pkg::*;
#(
    parameter logic [23:0] OUI_ID = 24'h5A3C71  // arbitrary value
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic [15:0] rx_fault_i,
    input  wire logic [15:0] tx_fault_i,
    input  wire logic        ls_fault_i,
    input  wire logic        phy_lf_i,
    input  wire logic        tx_valid_i,
    input  wire logic [63:0] tx_data_i,
    input  wire logic        tx_ctl_i,
    output logic             tx_valid_o,
    output logic [65:0]      tx_block_o,
    input  wire logic        rx_valid_i,
    input  wire logic [65:0] rx_block_i,
    output logic             rx_valid_o,
    output logic [63:0]      rx_data_o,
    output logic             rx_ctl_o,
    output logic             link_alarm_n_o,
    output logic             irq_o
);

    // ********************************************
    // bus slave
    // ********************************************
    logic        acc;
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [31:0] addr_q;
    logic [31:0] rd_d;
    logic [31:0] hrdata_q;

    // only whole-word single transfers arrive, so hsize needs no decode
    assign acc = hsel_i && hready_i && htrans_i[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 32'h0000_0000;
        end else begin
            wr_pend_q <= acc && hwrite_i;
            rd_pend_q <= acc && !hwrite_i;
            if (acc) begin
                addr_q <= haddr_i;
            end
        end
    end

    // reads wait one cycle so a write just before is already visible
    assign hreadyout_o = !rd_pend_q;
    assign hresp_o     = HRESP_OKAY;
    assign hrdata_o    = hrdata_q;

    logic wr_rx;
    logic wr_tx;
    logic wr_gm;
    logic wr_ctrl;
    logic wr_ins;
    logic wr_sts;
    logic wr_msk;

    assign wr_rx   = wr_pend_q && (addr_q == RX_EN_ADDR);
    assign wr_tx   = wr_pend_q && (addr_q == TX_EN_ADDR);
    assign wr_gm   = wr_pend_q && (addr_q == GMASK_ADDR);
    assign wr_ctrl = wr_pend_q && (addr_q == CTRL_ADDR);
    assign wr_ins  = wr_pend_q && (addr_q == INS_ADDR);
    assign wr_sts  = wr_pend_q && (addr_q == IRQ_STS_ADDR);
    assign wr_msk  = wr_pend_q && (addr_q == IRQ_MSK_ADDR);

    // ********************************************
    // alarm control registers
    // ********************************************
    logic [15:0] rx_en_q;
    logic [15:0] tx_en_q;
    logic [15:0] gmask_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_en_q <= RX_EN_RST;
        end else if (wr_rx) begin
            rx_en_q <= hwdata_i[15:0] & RX_EN_WMASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_en_q <= TX_EN_RST;
        end else if (wr_tx) begin
            tx_en_q <= hwdata_i[15:0] & TX_EN_WMASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gmask_q <= GMASK_RST;
        end else if (wr_gm) begin
            gmask_q <= hwdata_i[15:0] & GMASK_WMASK;
        end
    end

    // ********************************************
    // control and insertion settings
    // ********************************************
    logic [2:0]  ctrl_q;
    logic [15:0] ins_bad_q;
    logic [15:0] ins_good_q;
    logic        go_p;
    logic        halt_p;

    // go and halt are write-only strobes; they are not stored
    assign go_p   = wr_ctrl && hwdata_i[CTRL_GO_BIT];
    assign halt_p = wr_ctrl && hwdata_i[CTRL_HALT_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= hwdata_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ins_bad_q  <= INS_RUN_RST;
            ins_good_q <= INS_RUN_RST;
        end else if (wr_ins) begin
            ins_bad_q  <= hwdata_i[15:0];
            ins_good_q <= hwdata_i[31:16];
        end
    end

    // ********************************************
    // link alarm
    // ********************************************
    logic rx_act;
    logic tx_act;
    logic ls_act;
    logic alarm_q;

    assign rx_act = gmask_q[GM_RX_BIT] && |(rx_fault_i & rx_en_q);
    assign tx_act = gmask_q[GM_TX_BIT] && |(tx_fault_i & tx_en_q);
    assign ls_act = gmask_q[GM_LS_BIT] && ls_fault_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_q <= 1'b0;
        end else begin
            alarm_q <= ctrl_q[CTRL_MON_BIT] && (rx_act || tx_act || ls_act);
        end
    end

    assign link_alarm_n_o = !alarm_q;

    // ********************************************
    // error insertion generator
    // ********************************************
    lfa_ins_t    st_q;
    logic [15:0] cnt_q;
    logic        alt_q;
    logic [15:0] bad_len;
    logic [15:0] good_len;
    logic        done_p;

    assign bad_len  = lfa_run_len(ins_bad_q);
    assign good_len = lfa_run_len(ins_good_q);
    assign done_p   = tx_valid_i && (st_q == INS_GOOD) && (cnt_q == good_len - 16'h0001)
                      && !ctrl_q[CTRL_LOOP_BIT] && !halt_p;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q  <= INS_IDLE;
            cnt_q <= 16'h0000;
        end else if (halt_p) begin
            st_q  <= INS_IDLE;
            cnt_q <= 16'h0000;
        end else begin
            case (st_q)
                INS_IDLE: begin
                    if (go_p) begin
                        st_q  <= INS_BAD;
                        cnt_q <= 16'h0000;
                    end
                end
                INS_BAD: begin
                    if (tx_valid_i) begin
                        if (cnt_q == bad_len - 16'h0001) begin
                            st_q  <= INS_GOOD;
                            cnt_q <= 16'h0000;
                        end else begin
                            cnt_q <= cnt_q + 16'h0001;
                        end
                    end
                end
                INS_GOOD: begin
                    if (tx_valid_i) begin
                        if (cnt_q == good_len - 16'h0001) begin
                            st_q  <= ctrl_q[CTRL_LOOP_BIT] ? INS_BAD : INS_IDLE;
                            cnt_q <= 16'h0000;
                        end else begin
                            cnt_q <= cnt_q + 16'h0001;
                        end
                    end
                end
                default: begin
                    st_q  <= INS_IDLE;
                    cnt_q <= 16'h0000;
                end
            endcase
        end
    end

    // alternation restarts with type A on every start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alt_q <= 1'b0;
        end else if (go_p && st_q == INS_IDLE) begin
            alt_q <= 1'b0;
        end else if (tx_valid_i && st_q == INS_BAD && ctrl_q[CTRL_ALT_BIT]) begin
            alt_q <= !alt_q;
        end
    end

    // ********************************************
    // transmit path
    // ********************************************
    logic        rx_lf_q;
    logic        rx_rf_q;
    logic [63:0] tx_word;
    logic        tx_word_ctl;
    logic [1:0]  hdr_q;

    // insertion overrides fault handling during the bad-block run only; good-run blocks still follow it
    always_comb begin
        if (st_q == INS_BAD) begin
            tx_word     = (alt_q && ctrl_q[CTRL_ALT_BIT]) ? lfa_os_block(OS_RF) : lfa_os_block(OS_LF);
            tx_word_ctl = 1'b1;
        end else if (rx_lf_q || phy_lf_i) begin
            tx_word     = lfa_os_block(OS_RF);
            tx_word_ctl = 1'b1;
        end else if (rx_rf_q) begin
            tx_word     = BLK_IDLE;
            tx_word_ctl = 1'b1;
        end else begin
            tx_word     = tx_data_i;
            tx_word_ctl = tx_ctl_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hdr_q <= SYNC_DATA;
        end else if (tx_valid_i) begin
            hdr_q <= tx_word_ctl ? SYNC_CTL : SYNC_DATA;
        end
    end

    logic [63:0] tx_scr;

    lfa_scrambler #(
        .W       (64),
        .DESCRAM (1'b0)
    ) u_tx_scr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .valid_i (tx_valid_i),
        .data_i  (tx_word),
        .valid_o (tx_valid_o),
        .data_o  (tx_scr)
    );

    assign tx_block_o = {hdr_q, tx_scr};

    // ********************************************
    // receive path
    // ********************************************
    logic rx_ctl_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_ctl_q <= 1'b0;
        end else if (rx_valid_i) begin
            rx_ctl_q <= (rx_block_i[65:64] == SYNC_CTL);
        end
    end

    lfa_scrambler #(
        .W       (64),
        .DESCRAM (1'b1)
    ) u_rx_scr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .valid_i (rx_valid_i),
        .data_i  (rx_block_i[63:0]),
        .valid_o (rx_valid_o),
        .data_o  (rx_data_o)
    );

    assign rx_ctl_o = rx_ctl_q;

    logic rx_is_lf;
    logic rx_is_rf;

    assign rx_is_lf = rx_valid_o && rx_ctl_o && (rx_data_o == lfa_os_block(OS_LF));
    assign rx_is_rf = rx_valid_o && rx_ctl_o && (rx_data_o == lfa_os_block(OS_RF));

    // a fault holds until the first block that is not the same ordered set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_lf_q <= 1'b0;
            rx_rf_q <= 1'b0;
        end else if (rx_valid_o) begin
            rx_lf_q <= rx_is_lf;
            rx_rf_q <= rx_is_rf;
        end
    end

    // ********************************************
    // interrupt status and mask
    // ********************************************
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] irq_sts_q;
    logic [EV_W-1:0] irq_msk_q;

    always_comb begin
        ev           = '0;
        ev[EV_ALARM] = ctrl_q[CTRL_MON_BIT] && (rx_act || tx_act || ls_act) && !alarm_q;
        ev[EV_LF]    = rx_is_lf && !rx_lf_q;
        ev[EV_RF]    = rx_is_rf && !rx_rf_q;
        ev[EV_DONE]  = done_p;
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_sts_q <= EV_RST;
        end else begin
            irq_sts_q <= (irq_sts_q & ~(wr_sts ? hwdata_i[EV_W-1:0] : EV_RST)) | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_msk_q <= EV_RST;
        end else if (wr_msk) begin
            irq_msk_q <= hwdata_i[EV_W-1:0];
        end
    end

    assign irq_o = |(irq_sts_q & irq_msk_q);

    // ********************************************
    // read data
    // ********************************************
    always_comb begin
        if (addr_q == RX_EN_ADDR) begin
            rd_d = {16'h0000, rx_en_q};
        end else if (addr_q == TX_EN_ADDR) begin
            rd_d = {16'h0000, tx_en_q};
        end else if (addr_q == GMASK_ADDR) begin
            rd_d = {16'h0000, gmask_q};
        end else if (addr_q == CTRL_ADDR) begin
            rd_d = {29'h0000_0000, ctrl_q};
        end else if (addr_q == INS_ADDR) begin
            rd_d = {ins_good_q, ins_bad_q};
        end else if (addr_q == IRQ_STS_ADDR) begin
            rd_d = {28'h000_0000, irq_sts_q};
        end else if (addr_q == IRQ_MSK_ADDR) begin
            rd_d = {28'h000_0000, irq_msk_q};
        end else if (addr_q == STATUS_ADDR) begin
            rd_d = {27'h000_0000, st_q, rx_rf_q, rx_lf_q, alarm_q};
        end else if (addr_q == OUI_ADDR) begin
            rd_d = {8'h00, OUI_ID};
        end else begin
            rd_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            hrdata_q <= rd_d;
        end
    end

    // ********************************************
    // assertions
    // ********************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_mon_off_quiet: assert property (!ctrl_q[CTRL_MON_BIT] |=> link_alarm_n_o)
        else $error("alarm asserted with monitoring off");
    a_alarm_follow: assert property (ctrl_q[CTRL_MON_BIT] && rx_act |=> !link_alarm_n_o)
        else $error("enabled receive fault did not pull the alarm low");
    a_alarm_gated: assert property ((gmask_q == 16'h0000) |=> link_alarm_n_o)
        else $error("alarm asserted with all groups masked");
    a_rx_en_reset: assert property ($past(rst_i) |-> rx_en_q == RX_EN_RST)
        else $error("receive enable reset value wrong");
    a_tx_en_reset: assert property ($past(rst_i) |-> tx_en_q == TX_EN_RST && gmask_q == GMASK_RST)
        else $error("transmit enable or global mask reset value wrong");
    a_resv_zero: assert property (rx_en_q[15:11] == 5'h00 && tx_en_q[15:11] == 5'h00 && gmask_q[15:8] == 8'h00)
        else $error("reserved alarm bits not zero");
    a_rf_answer: assert property (st_q != INS_BAD && phy_lf_i |-> tx_word == lfa_os_block(OS_RF))
        else $error("local fault did not produce remote fault");
    a_idle_only: assert property (st_q != INS_BAD && !rx_lf_q && !phy_lf_i && rx_rf_q |-> tx_word == BLK_IDLE)
        else $error("data sent during remote fault");
    a_bad_os: assert property (st_q == INS_BAD |-> tx_word[39:8] == OS_LF || tx_word[39:8] == OS_RF)
        else $error("bad block is not a fault ordered set");
    a_sync_hdr: assert property (tx_valid_i && tx_word_ctl |=> tx_valid_o && tx_block_o[65:64] == SYNC_CTL)
        else $error("control block without control sync header");
    a_rx_latency: assert property (rx_valid_i |=> rx_valid_o && rx_ctl_o == ($past(rx_block_i[65:64]) == SYNC_CTL))
        else $error("receive word not recovered one cycle later");
    a_bad_run: assert property (st_q == INS_GOOD && $past(st_q) == INS_BAD |-> $past(cnt_q) == $past(bad_len) - 16'h0001)
        else $error("bad run length wrong");
    a_once_ends: assert property (done_p |=> st_q == INS_IDLE && irq_sts_q[EV_DONE])
        else $error("single pass did not end");
    a_type_a_only: assert property (st_q == INS_BAD && !ctrl_q[CTRL_ALT_BIT] && $past(go_p) |-> tx_word == lfa_os_block(OS_LF))
        else $error("first bad block is not type A");

    c_alarm_low: cover property (ctrl_q[CTRL_MON_BIT] ##1 !link_alarm_n_o);
    c_ins_loop: cover property (st_q == INS_GOOD ##1 st_q == INS_BAD);
    c_ins_done: cover property (done_p);
    c_rf_seen: cover property (rx_is_rf ##1 rx_rf_q);

endmodule
`default_nettype wire

// ### src/lfa_pkg.sv
// lfa_pkg: constants, types and helpers for the link fault alarm block
package lfa_pkg;

    // ********************************************
    // register indices and byte addresses
    // ********************************************
    localparam logic [15:0] TX_EN_IDX    = 16'h9001;
    localparam logic [15:0] GMASK_IDX    = 16'h9002;
    localparam logic [15:0] RX_EN_IDX    = 16'h9003;
    localparam logic [31:0] TX_EN_ADDR   = {14'h0000, TX_EN_IDX, 2'b00};
    localparam logic [31:0] GMASK_ADDR   = {14'h0000, GMASK_IDX, 2'b00};
    localparam logic [31:0] RX_EN_ADDR   = {14'h0000, RX_EN_IDX, 2'b00};
    localparam logic [31:0] CTRL_ADDR    = 32'h0000_0000;
    localparam logic [31:0] INS_ADDR     = 32'h0000_0004;
    localparam logic [31:0] IRQ_STS_ADDR = 32'h0000_0008;
    localparam logic [31:0] IRQ_MSK_ADDR = 32'h0000_000C;
    localparam logic [31:0] STATUS_ADDR  = 32'h0000_0010;
    localparam logic [31:0] OUI_ADDR     = 32'h0000_0014;

    // ********************************************
    // reset values, writable masks, field positions
    // ********************************************
    localparam logic [15:0] RX_EN_RST    = 16'h0239;
    localparam logic [15:0] RX_EN_WMASK  = 16'h07FF;
    localparam logic [15:0] TX_EN_RST    = 16'h03D9;
    localparam logic [15:0] TX_EN_WMASK  = 16'h07FF;
    localparam logic [15:0] GMASK_RST    = 16'h0000;
    localparam logic [15:0] GMASK_WMASK  = 16'h00FF;
    localparam int          GM_RX_BIT    = 2;
    localparam int          GM_TX_BIT    = 1;
    localparam int          GM_LS_BIT    = 0;
    localparam int          CTRL_MON_BIT = 0;
    localparam int          CTRL_ALT_BIT = 1;
    localparam int          CTRL_LOOP_BIT = 2;
    localparam int          CTRL_GO_BIT  = 3;
    localparam int          CTRL_HALT_BIT = 4;
    localparam logic [2:0]  CTRL_RST     = 3'h0;
    localparam logic [15:0] INS_MIN      = 16'h0002;
    localparam logic [15:0] INS_RUN_RST  = 16'h0002;
    localparam int          EV_W         = 4;
    localparam int          EV_ALARM     = 0;
    localparam int          EV_LF        = 1;
    localparam int          EV_RF        = 2;
    localparam int          EV_DONE      = 3;
    localparam logic [3:0]  EV_RST       = 4'h0;
    localparam logic        HRESP_OKAY   = 1'b0;

    // ********************************************
    // block coding
    // ********************************************
    localparam logic [1:0]  SYNC_DATA    = 2'b01;
    localparam logic [1:0]  SYNC_CTL     = 2'b10;
    localparam logic [31:0] OS_LF        = 32'h0100_009C;
    localparam logic [31:0] OS_RF        = 32'h0200_009C;
    localparam logic [7:0]  BLK_OS_TYPE  = 8'h4B;
    localparam logic [63:0] BLK_IDLE     = 64'h0000_0000_0000_001E;

    typedef enum logic [1:0] {
        INS_IDLE = 2'b00,
        INS_BAD  = 2'b01,
        INS_GOOD = 2'b10
    } lfa_ins_t;

    // ordered set placed in a control block after the block type byte
    function automatic logic [63:0] lfa_os_block(input logic [31:0] os);
        return {24'h000000, os, BLK_OS_TYPE};
    endfunction

    // run lengths below the minimum are raised to it
    function automatic logic [15:0] lfa_run_len(input logic [15:0] len);
        return (len < INS_MIN) ? INS_MIN : len;
    endfunction

endpackage

// ### src/lfa_scrambler.sv
// lfa_scrambler: self-synchronising x^58+x^39+1 scrambler or descrambler
`timescale 1ns/1ps
`default_nettype none
module lfa_scrambler #(
    parameter int W       = 64,
    parameter bit DESCRAM = 1'b0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         valid_i,
    input  wire logic [W-1:0] data_i,
    output logic              valid_o,
    output logic [W-1:0]      data_o
);
    logic [57:0]     st_q;
    logic [W+57:0]   ext;
    logic [W-1:0]    res;

    // bit 0 goes first; ext holds the history followed by the new line bits
    always_comb begin
        ext = '0;
        res = '0;
        ext[57:0] = st_q;
        for (int i = 0; i < W; i++) begin
            res[i] = data_i[i] ^ ext[i + 19] ^ ext[i];
            ext[i + 58] = DESCRAM ? data_i[i] : res[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else if (valid_i) begin
            st_q <= ext[W+57:W];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_o  <= '0;
            valid_o <= 1'b0;
        end else begin
            valid_o <= valid_i;
            if (valid_i) begin
                data_o <= res;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/lfa_far_end.sv
// lfa_far_end: remote phy model that hands transmitted blocks straight back
`timescale 1ns/1ps
`default_nettype none
module lfa_far_end (
    input  wire logic        clk_i,
    input  wire logic        valid_i,
    input  wire logic [65:0] block_i,
    output logic             valid_o,
    output logic [65:0]      block_o
);
    logic [65:0] last_q;
    always_ff @(posedge clk_i) last_q <= block_o;
    // the remote side returns each fault or idle block it is sent
    assign valid_o = valid_i;
    // between blocks the lines alternate between the inverse of the last block and the last block itself
    assign block_o = valid_i ? block_i : ~last_q;
endmodule
`default_nettype wire

// ### verif/tb.sv
// tb: self-checking bench for the link fault alarm core
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lfa_pkg::*;
    localparam logic [23:0] OUI = 24'hC3A52E; // arbitrary value
    localparam logic [64:0] LF  = {1'b1, 24'h0, OS_LF, BLK_OS_TYPE};
    localparam logic [64:0] RF  = {1'b1, 24'h0, OS_RF, BLK_OS_TYPE};
    localparam logic [64:0] IDL = {1'b1, BLK_IDLE};
    logic        clk = 0, rst = 1, hsel = 0, hw = 0, txv = 0, plf = 0, lsf = 0, tc = 0;
    logic        hrdy, rv, lan, irq, rxv, rc, tv;
    logic [1:0]  ht = 0;
    logic [31:0] ha = 0, hwd = 0, hrd, r;
    logic [15:0] rxf = 0, txf = 0, lfsr = 16'hEFFC;
    logic [63:0] td = 0, rd;
    logic [65:0] tbk, rb;
    logic [64:0] q[$];
    logic [64:0] ins_seq[3][5] = '{'{LF, LF, RF, IDL, 65'h0}, '{LF, RF, IDL, 65'h0, 65'h0},
                                   '{LF, LF, RF, IDL, LF}};
    int          error_cnt = 0, n_tests = 0;
    always #12.5 clk = ~clk;
    lfa_core #(.OUI_ID(OUI)) i_lfa_core (.clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(ha), .htrans_i(ht),
        .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy), .hrdata_o(hrd), .hreadyout_o(hrdy),
        .hresp_o(), .rx_fault_i(rxf), .tx_fault_i(txf), .ls_fault_i(lsf), .phy_lf_i(plf), .tx_valid_i(txv),
        .tx_data_i(td), .tx_ctl_i(tc), .tx_valid_o(tv), .tx_block_o(tbk), .rx_valid_i(rv), .rx_block_i(rb),
        .rx_valid_o(rxv), .rx_data_o(rd), .rx_ctl_o(rc), .link_alarm_n_o(lan), .irq_o(irq));
    lfa_far_end i_lfa_far_end (.clk_i(clk), .valid_i(tv), .block_i(tbk), .valid_o(rv), .block_o(rb));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic close_out();
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [64:0] g, input logic [64:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        ht <= 2'h2;
        hsel <= 1'b1;
        ha <= a;
        hw <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        ht <= 2'h0;
        hwd <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrd;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    // an all-zero note means the random mac word and its control flag must come back
    task automatic send(input logic [64:0] e);
        logic [63:0] d;
        logic        c;
        @(posedge clk);
        lfsr = nx(nx(lfsr));
        d = {lfsr, ~lfsr, lfsr ^ 16'h5A5A, nx(lfsr)};
        c = lfsr[3];
        txv <= 1'b1;
        td <= d;
        tc <= c;
        q.push_back(e === 65'h0 ? {c, d} : e);
        @(posedge clk);
        txv <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic al(input logic e);
        repeat (2) @(posedge clk);
        chk(lan, e);
    endtask
    always @(posedge clk) if (rxv === 1'b1) chk({rc, rd}, q.size() ? q.pop_front() : 'x);
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdc(RX_EN_ADDR, 32'h0000_0239);
        rdc(TX_EN_ADDR, 32'h0000_03D9);
        rdc(GMASK_ADDR, 32'h0);
        rdc(OUI_ADDR, {8'h00, OUI});
        bus(1'b1, RX_EN_ADDR, 32'hFFFF_FFFF);
        rdc(RX_EN_ADDR, 32'h0000_07FF);
        rdc(32'h0000_0100, 32'h0);
        bus(1'b1, CTRL_ADDR, 32'h1);
        bus(1'b1, GMASK_ADDR, 32'h7);
        rxf <= 16'h0008;
        al(1'b0);
        chk(irq, 1'b0);
        bus(1'b1, IRQ_MSK_ADDR, 32'h1);
        @(posedge clk);
        chk(irq, 1'b1);
        bus(1'b1, RX_EN_ADDR, 32'h0);
        al(1'b1);
        txf <= 16'h0040;
        al(1'b0);
        bus(1'b1, GMASK_ADDR, 32'h5);
        al(1'b1);
        lsf <= 1'b1;
        al(1'b0);
        bus(1'b1, CTRL_ADDR, 32'h0);
        al(1'b1);
        bus(1'b1, IRQ_STS_ADDR, 32'hF);
        @(posedge clk);
        chk(irq, 1'b0);
        repeat (4) send(65'h0);
        plf <= 1'b1;
        repeat (2) send(RF);
        plf <= 1'b0;
        send(IDL);
        send(65'h0);
        bus(1'b1, INS_ADDR, 32'h0);
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, CTRL_ADDR, 32'h8 | (m << 1));
            for (int k = 0; k < 5; k++) send(ins_seq[m][k]);
        end
        // stop the endless loop; the held local fault answers, then the link settles
        bus(1'b1, CTRL_ADDR, 32'h10);
        send(RF);
        send(IDL);
        send(65'h0);
        rdc(IRQ_STS_ADDR, 32'hE);
        repeat (10) @(posedge clk);
        chk(q.size(), 65'h0);
        close_out();
    end
endmodule
`default_nettype wire
